// *** src/misc_cfg_pkg.sv ***
/*
 * constants, register map and address decode for the per-setup misc
 * configuration bank.
 * assumes an apb slave port with 12-bit byte addresses and 32-bit data.
 */
package misc_cfg_pkg;

    // ------------------------------------------------------------
    // register map
    // ------------------------------------------------------------
    localparam int NUM_SETUPS = 8;
    localparam int ADDR_W = 12;
    localparam int CONV_W = 24;
    // printed offsets are register indices; byte address is index * 4
    localparam logic [9:0] SETUP_IDX [NUM_SETUPS] = '{
        10'h0C0, 10'h0CE, 10'h0DC, 10'h0EA, 10'h0F8, 10'h106, 10'h114, 10'h122
    };

    // ------------------------------------------------------------
    // fields and values
    // ------------------------------------------------------------
    localparam int EXC_MSB = 15;
    localparam int EXC_LSB = 14;
    localparam int MUX_MSB = 9;
    localparam int MUX_LSB = 8;
    localparam int BURN_MSB = 1;
    localparam int BURN_LSB = 0;
    localparam logic [15:0] CFG_RESET = 16'h0000;
    localparam logic [15:0] CFG_WMASK = 16'hC303;
    localparam logic [1:0] CHOP_ON = 2'h1;
    localparam logic [1:0] BURN_100NA = 2'h1;
    localparam logic [1:0] BURN_2UA = 2'h2;
    localparam logic [1:0] BURN_10UA = 2'h3;

    // ------------------------------------------------------------
    // decode: {hit, setup index}
    // ------------------------------------------------------------
    function automatic logic [3:0] decode_setup(input logic [ADDR_W-1:0] addr);
        logic [3:0] res;
        res = 4'h0;
        for (int i = 0; i < NUM_SETUPS; i++) begin
            if (addr[ADDR_W-1:2] == SETUP_IDX[i] && addr[1:0] == 2'h0) begin
                res = {1'b1, 3'(i)};
            end
        end
        return res;
    endfunction

endpackage

// *** src/chop_if.sv ***
/*
 * link between the register bank and the chop phase sequencer.
 * assumes both ends share ref_clk.
 */
`timescale 1ns/1ps
interface chop_if;
    logic exc_chop;
    logic mux_chop;
    logic restart;
    logic conv_done;
    logic [23:0] conv_data;
    logic exc_swap;
    logic mux_swap;
    logic avg_valid;
    logic [23:0] avg_data;

    modport ctrl (
        output exc_chop, mux_chop, restart, conv_done, conv_data,
        input exc_swap, mux_swap, avg_valid, avg_data
    );
    modport seq (
        input exc_chop, mux_chop, restart, conv_done, conv_data,
        output exc_swap, mux_swap, avg_valid, avg_data
    );
endinterface

// *** src/chop_phase_seq.sv ***
/*
 * chop phase sequencer: swaps excitation pins and mux polarity per
 * conversion and averages the two phases.
 * assumes conv_data is already polarity corrected, twos complement.
 */
`timescale 1ns/1ps
module chop_phase_seq (
    input wire logic ref_clk,
    input wire logic nrst,
    chop_if.seq cb
);
    import misc_cfg_pkg::*;

    typedef enum logic {PH_FIRST, PH_SECOND} chop_phase_t;

    chop_phase_t phase_reg;
    logic [CONV_W-1:0] first_reg;
    logic chopping;
    logic [CONV_W:0] sum;

    assign chopping = cb.exc_chop | cb.mux_chop;
    assign sum = {first_reg[CONV_W-1], first_reg} + {cb.conv_data[CONV_W-1], cb.conv_data};

    // ------------------------------------------------------------
    // phase
    // ------------------------------------------------------------
    always_ff @(posedge ref_clk or negedge nrst) begin
        if (!nrst) begin
            phase_reg <= PH_FIRST;
        end else if (cb.restart || !chopping) begin
            phase_reg <= PH_FIRST;
        end else if (cb.conv_done) begin
            case (phase_reg)
                PH_FIRST: phase_reg <= PH_SECOND;
                PH_SECOND: phase_reg <= PH_FIRST;
                default: phase_reg <= PH_FIRST;
            endcase
        end
    end

    // ------------------------------------------------------------
    // pin swaps
    // ------------------------------------------------------------
    always_ff @(posedge ref_clk or negedge nrst) begin
        if (!nrst) begin
            cb.exc_swap <= 1'b0;
        end else if (cb.restart || !cb.exc_chop) begin
            cb.exc_swap <= 1'b0; // [RULE_04]
        end else if (cb.conv_done) begin
            cb.exc_swap <= !cb.exc_swap; // [RULE_05]
        end
    end

    always_ff @(posedge ref_clk or negedge nrst) begin
        if (!nrst) begin
            cb.mux_swap <= 1'b0;
        end else if (cb.restart || !cb.mux_chop) begin
            cb.mux_swap <= 1'b0; // [RULE_07]
        end else if (cb.conv_done) begin
            cb.mux_swap <= !cb.mux_swap; // [RULE_08]
        end
    end

    // ------------------------------------------------------------
    // averaging; first chop phase yields no result, unchopped conversions pass straight out
    // ------------------------------------------------------------
    always_ff @(posedge ref_clk or negedge nrst) begin
        if (!nrst) begin
            first_reg <= '0;
            cb.avg_valid <= 1'b0;
            cb.avg_data <= '0;
        end else begin
            cb.avg_valid <= 1'b0;
            if (cb.conv_done && !cb.restart) begin
                if (!chopping) begin
                    cb.avg_valid <= 1'b1;
                    cb.avg_data <= cb.conv_data;
                end else if (phase_reg == PH_FIRST) begin
                    first_reg <= cb.conv_data; // [RULE_09]
                end else begin
                    cb.avg_valid <= 1'b1;
                    cb.avg_data <= sum[CONV_W:1]; // [RULE_05] [RULE_08]
                end
            end
        end
    end

endmodule // chop_phase_seq

// *** src/setup_misc_config_regs.sv ***
/*
 * per-setup misc configuration bank: eight registers on apb, chop control
 * and burnout current enables for the active setup.
 * assumes the sequencer supplies active_setup, channel_selected and
 * conversion results synchronous to ref_clk.
 */
// Design decision made here: register access over APB.
// Behaviour
// RULE_01 - eight 16-bit registers at indices 0xC0..0x122, step 14, reset zero.
// RULE_02 - register n applies only to conversions using setup n.
// RULE_03 - any write to the bank restarts filter, control logic and sequencer.
// RULE_04 - excitation chop field bits 15:14; zero means pins never swapped.
// RULE_05 - code one swaps excitation pins each conversion and averages phases.
// RULE_06 - host sets both excitation currents equal when chopping.
// RULE_07 - mux chop field bits 9:8; zero means no input chopping.
// RULE_08 - code one swaps mux inputs each conversion and averages results.
// RULE_09 - mux chop settling needs both polarities before a first result.
// RULE_10 - burnout bits 1:0: off, 100nA, 2uA, 10uA.
// RULE_11 - burnout currents only while a channel of this setup is selected.
// RULE_12 - reserved bits read zero, ignore writes; reserved chop codes mean off.
`timescale 1ns/1ps
module setup_misc_config_regs (
    input wire logic ref_clk,
    input wire logic nrst,
    input wire logic psel,
    input wire logic penable,
    input wire logic pwrite,
    input wire logic [misc_cfg_pkg::ADDR_W-1:0] paddr,
    input wire logic [31:0] pwdata,
    output logic [31:0] prdata,
    output logic pready,
    output logic pslverr,
    input wire logic [2:0] active_setup,
    input wire logic channel_selected,
    input wire logic conv_done,
    input wire logic [misc_cfg_pkg::CONV_W-1:0] conv_data,
    output logic seq_restart,
    output logic excitation_out_swap,
    output logic mux_input_swap,
    output logic result_valid,
    output logic [misc_cfg_pkg::CONV_W-1:0] result_data,
    output logic burnout_100na_en,
    output logic burnout_2ua_en,
    output logic burnout_10ua_en
);
    import misc_cfg_pkg::*;

    // ------------------------------------------------------------
    // declarations
    // ------------------------------------------------------------
    logic [15:0] cfg_reg [NUM_SETUPS];
    logic [31:0] prdata_reg;
    logic pready_reg;
    logic pslverr_reg;
    logic seq_restart_reg;
    logic burn_100na_reg;
    logic burn_2ua_reg;
    logic burn_10ua_reg;
    logic [2:0] setup_prev_reg;
    logic [3:0] dec;
    logic sel_hit;
    logic [2:0] sel_idx;
    logic access;
    logic wr_fire;
    logic setup_changed;
    logic [15:0] cur_cfg;

    chop_if cb();

    // ------------------------------------------------------------
    // apb decode
    // ------------------------------------------------------------
    assign dec = decode_setup(paddr);
    assign sel_hit = dec[3];
    assign sel_idx = dec[2:0];
    assign access = psel & penable;
    // one wait state: pready rises on the second access cycle
    assign wr_fire = access & pready_reg & pwrite & sel_hit;

    always_ff @(posedge ref_clk or negedge nrst) begin
        if (!nrst) begin
            pready_reg <= 1'b0;
        end else begin
            pready_reg <= access & ~pready_reg;
        end
    end

    // read data and error are registered on the same edge that raises pready
    always_ff @(posedge ref_clk or negedge nrst) begin
        if (!nrst) begin
            prdata_reg <= 32'h00000000;
            pslverr_reg <= 1'b0;
        end else if (access && !pready_reg) begin
            pslverr_reg <= ~sel_hit;
            if (!pwrite && sel_hit) begin
                prdata_reg <= {16'h0000, cfg_reg[sel_idx]}; // [RULE_12]
            end else begin
                prdata_reg <= 32'h00000000;
            end
        end else begin
            pslverr_reg <= 1'b0;
        end
    end

    // ------------------------------------------------------------
    // register storage
    // ------------------------------------------------------------
    always_ff @(posedge ref_clk or negedge nrst) begin
        if (!nrst) begin
            for (int i = 0; i < NUM_SETUPS; i++) begin
                cfg_reg[i] <= CFG_RESET; // [RULE_01]
            end
        end else if (wr_fire) begin
            cfg_reg[sel_idx] <= pwdata[15:0] & CFG_WMASK; // [RULE_01] [RULE_12]
        end
    end

    // ------------------------------------------------------------
    // restart
    // ------------------------------------------------------------
    // the sequencer owns setup changes, so only bus writes go out as a
    // restart; a setup change just realigns the local chop phase
    always_ff @(posedge ref_clk or negedge nrst) begin
        if (!nrst) begin
            seq_restart_reg <= 1'b0;
        end else begin
            seq_restart_reg <= wr_fire; // [RULE_03]
        end
    end

    always_ff @(posedge ref_clk or negedge nrst) begin
        if (!nrst) begin
            setup_prev_reg <= 3'h0;
        end else begin
            setup_prev_reg <= active_setup;
        end
    end

    assign setup_changed = active_setup != setup_prev_reg;

    // ------------------------------------------------------------
    // active setup controls
    // ------------------------------------------------------------
    assign cur_cfg = cfg_reg[active_setup]; // [RULE_02]
    // reserved codes fall through as off
    assign cb.exc_chop = cur_cfg[EXC_MSB:EXC_LSB] == CHOP_ON; // [RULE_04] [RULE_12]
    assign cb.mux_chop = cur_cfg[MUX_MSB:MUX_LSB] == CHOP_ON; // [RULE_07] [RULE_12]
    assign cb.restart = wr_fire | setup_changed; // [RULE_03]
    assign cb.conv_done = conv_done;
    assign cb.conv_data = conv_data;

    chop_phase_seq u_seq (
        .ref_clk(ref_clk),
        .nrst(nrst),
        .cb(cb.seq)
    );

    // ------------------------------------------------------------
    // burnout current enables
    // ------------------------------------------------------------
    always_ff @(posedge ref_clk or negedge nrst) begin
        if (!nrst) begin
            burn_100na_reg <= 1'b0;
            burn_2ua_reg <= 1'b0;
            burn_10ua_reg <= 1'b0;
        end else if (!channel_selected) begin
            burn_100na_reg <= 1'b0; // [RULE_11]
            burn_2ua_reg <= 1'b0;
            burn_10ua_reg <= 1'b0;
        end else begin
            burn_100na_reg <= cur_cfg[BURN_MSB:BURN_LSB] == BURN_100NA; // [RULE_10]
            burn_2ua_reg <= cur_cfg[BURN_MSB:BURN_LSB] == BURN_2UA;
            burn_10ua_reg <= cur_cfg[BURN_MSB:BURN_LSB] == BURN_10UA;
        end
    end

    // ------------------------------------------------------------
    // outputs
    // ------------------------------------------------------------
    assign prdata = prdata_reg;
    assign pready = pready_reg;
    assign pslverr = pslverr_reg;
    assign seq_restart = seq_restart_reg;
    assign excitation_out_swap = cb.exc_swap;
    assign mux_input_swap = cb.mux_swap;
    assign result_valid = cb.avg_valid;
    assign result_data = cb.avg_data;
    assign burnout_100na_en = burn_100na_reg;
    assign burnout_2ua_en = burn_2ua_reg;
    assign burnout_10ua_en = burn_10ua_reg;

    // ------------------------------------------------------------
    // checks
    // ------------------------------------------------------------
    chk_wr_store: // [RULE_01]
    assert property (@(posedge ref_clk) disable iff (!nrst)
        wr_fire |=> cfg_reg[$past(sel_idx)] == ($past(pwdata[15:0]) & CFG_WMASK))
    else $error("written value not stored");

    chk_setup_isolate: // [RULE_02]
    assert property (@(posedge ref_clk) disable iff (!nrst)
        (wr_fire && sel_idx != active_setup) ##1 $stable(active_setup) |-> $stable(cur_cfg))
    else $error("write to other setup changed active controls");

    chk_wr_restart: // [RULE_03]
    assert property (@(posedge ref_clk) disable iff (!nrst)
        wr_fire |=> seq_restart ##1 !seq_restart)
    else $error("write did not pulse restart");

    chk_exc_off: // [RULE_04]
    assert property (@(posedge ref_clk) disable iff (!nrst)
        !cb.exc_chop |=> !excitation_out_swap)
    else $error("excitation swapped with chopping off");

    chk_exc_toggle: // [RULE_05]
    assert property (@(posedge ref_clk) disable iff (!nrst)
        cb.exc_chop && conv_done && !cb.restart |=> excitation_out_swap != $past(excitation_out_swap))
    else $error("excitation swap did not toggle");

    chk_mux_off: // [RULE_07]
    assert property (@(posedge ref_clk) disable iff (!nrst)
        !cb.mux_chop |=> !mux_input_swap)
    else $error("mux swapped with chopping off");

    chk_mux_pair: // [RULE_08]
    assert property (@(posedge ref_clk) disable iff (!nrst)
        cb.mux_chop && mux_input_swap && conv_done && !cb.restart |=> result_valid && !mux_input_swap)
    else $error("second polarity gave no result");

    chk_mux_settle: // [RULE_09]
    assert property (@(posedge ref_clk) disable iff (!nrst)
        cb.mux_chop && !mux_input_swap && conv_done && !cb.restart |=> !result_valid)
    else $error("result after one polarity only");

    chk_burn_level: // [RULE_10]
    assert property (@(posedge ref_clk) disable iff (!nrst)
        channel_selected && cur_cfg[BURN_MSB:BURN_LSB] == BURN_2UA
        |=> burnout_2ua_en && !burnout_100na_en && !burnout_10ua_en)
    else $error("burnout level decode wrong");

    chk_burn_gate: // [RULE_11]
    assert property (@(posedge ref_clk) disable iff (!nrst)
        !channel_selected |=> !burnout_100na_en && !burnout_2ua_en && !burnout_10ua_en)
    else $error("burnout active without channel");

    chk_rsvd_read: // [RULE_12]
    assert property (@(posedge ref_clk) disable iff (!nrst)
        pready |-> (prdata & ~{16'h0000, CFG_WMASK}) == 32'h00000000)
    else $error("reserved bits read nonzero");

    chk_unmapped_err: // [RULE_12]
    assert property (@(posedge ref_clk) disable iff (!nrst)
        access && !pready && !sel_hit |=> pready && pslverr && prdata == 32'h00000000)
    else $error("unmapped access not flagged");

    chk_ready_wait: // [RULE_01]
    assert property (@(posedge ref_clk) disable iff (!nrst)
        access && !pready |=> pready)
    else $error("no ready after one wait state");

    chk_ready_idle: // [RULE_01]
    assert property (@(posedge ref_clk) disable iff (!nrst)
        !access |=> !pready && !pslverr)
    else $error("ready without an access");

    chk_rd_data: // [RULE_01]
    assert property (@(posedge ref_clk) disable iff (!nrst)
        access && !pready && !pwrite && sel_hit
        |=> prdata == {16'h0000, cfg_reg[$past(sel_idx)]})
    else $error("read data not the addressed register");

    chk_err_pulse: // [RULE_12]
    assert property (@(posedge ref_clk) disable iff (!nrst)
        pslverr |-> pready)
    else $error("error without ready");

    chk_refused_quiet: // [RULE_12]
    assert property (@(posedge ref_clk) disable iff (!nrst)
        access && pready && !sel_hit |=> !seq_restart)
    else $error("refused write restarted the sequencer");

    chk_restart_src: // [RULE_03]
    assert property (@(posedge ref_clk) disable iff (!nrst)
        seq_restart |-> $past(wr_fire))
    else $error("restart without a write");

    chk_restart_swaps: // [RULE_03]
    assert property (@(posedge ref_clk) disable iff (!nrst)
        cb.restart |=> !excitation_out_swap && !mux_input_swap)
    else $error("restart left a pin swap set");

    chk_restart_drop: // [RULE_03]
    assert property (@(posedge ref_clk) disable iff (!nrst)
        cb.restart |=> !result_valid)
    else $error("result given across a restart");

    chk_mux_toggle: // [RULE_08]
    assert property (@(posedge ref_clk) disable iff (!nrst)
        cb.mux_chop && conv_done && !cb.restart |=> mux_input_swap != $past(mux_input_swap))
    else $error("mux swap did not toggle");

    chk_exc_pair: // [RULE_05]
    assert property (@(posedge ref_clk) disable iff (!nrst)
        cb.exc_chop && excitation_out_swap && conv_done && !cb.restart
        |=> result_valid && !excitation_out_swap)
    else $error("second excitation phase gave no result");

    chk_exc_settle: // [RULE_05]
    assert property (@(posedge ref_clk) disable iff (!nrst)
        cb.exc_chop && !excitation_out_swap && conv_done && !cb.restart |=> !result_valid)
    else $error("result after one excitation phase only");

    chk_nochop_pass: // [RULE_12]
    assert property (@(posedge ref_clk) disable iff (!nrst)
        !cb.exc_chop && !cb.mux_chop && conv_done && !cb.restart
        |=> result_valid && result_data == $past(conv_data))
    else $error("unchopped result not passed through");

    chk_valid_src: // [RULE_05]
    assert property (@(posedge ref_clk) disable iff (!nrst)
        result_valid |-> $past(conv_done))
    else $error("result without a conversion");

    chk_burn_off: // [RULE_10]
    assert property (@(posedge ref_clk) disable iff (!nrst)
        channel_selected && cur_cfg[BURN_MSB:BURN_LSB] == 2'h0
        |=> !burnout_100na_en && !burnout_2ua_en && !burnout_10ua_en)
    else $error("burnout on with field off");

    chk_burn_low: // [RULE_10]
    assert property (@(posedge ref_clk) disable iff (!nrst)
        channel_selected && cur_cfg[BURN_MSB:BURN_LSB] == BURN_100NA
        |=> burnout_100na_en && !burnout_2ua_en && !burnout_10ua_en)
    else $error("lowest burnout level decode wrong");

    chk_burn_high: // [RULE_10]
    assert property (@(posedge ref_clk) disable iff (!nrst)
        channel_selected && cur_cfg[BURN_MSB:BURN_LSB] == BURN_10UA
        |=> burnout_10ua_en && !burnout_100na_en && !burnout_2ua_en)
    else $error("highest burnout level decode wrong");

    chk_burn_onehot: // [RULE_10]
    assert property (@(posedge ref_clk) disable iff (!nrst)
        $onehot0({burnout_100na_en, burnout_2ua_en, burnout_10ua_en}))
    else $error("more than one burnout level on");

endmodule // setup_misc_config_regs

// *** tb/apb_host_model.sv ***
/*
 * apb host model: issues register transfers on behalf of the bench.
 * assumes every task is entered right after a rising edge of ref_clk.
 */
`timescale 1ns/1ps
module apb_host_model (
    input wire logic ref_clk,
    output logic psel,
    output logic penable,
    output logic pwrite,
    output logic [11:0] paddr,
    output logic [31:0] pwdata,
    input wire logic [31:0] prdata,
    input wire logic pready,
    input wire logic pslverr
);
    initial begin
        psel = 1'b0;
        penable = 1'b0;
        pwrite = 1'b0;
        paddr = 12'h000;
        pwdata = 32'h0;
    end

    // ------------------------------------------------------------
    // one transfer, held until pready; err comes back x on no answer
    // ------------------------------------------------------------
    task automatic xfer(input logic wr, input logic [11:0] a, input logic [31:0] wd,
                        output logic [31:0] rd, output logic err);
        psel <= 1'b1;
        penable <= 1'b0;
        pwrite <= wr;
        paddr <= a;
        pwdata <= wd;
        rd = 32'h0;
        err = 1'bx;
        @(posedge ref_clk);
        penable <= 1'b1;
        // read at the edge itself, before the slave's own update lands
        for (int n = 0; n < 16; n++) begin
            @(posedge ref_clk);
            if (pready === 1'b1) begin
                rd = prdata;
                err = pslverr;
                return;
            end
        end
    endtask

    // idle lines show inverted stale values, not the last request
    task automatic go_idle();
        psel <= 1'b0;
        penable <= 1'b0;
        paddr <= ~paddr;
        pwdata <= ~pwdata;
    endtask
endmodule // apb_host_model

// *** tb/setup_misc_config_regs_test.sv ***
/*
 * self-checking bench for the per-setup misc configuration bank.
 * assumes the design package and the apb host model are compiled first.
 */
`timescale 1ns/1ps
module setup_misc_config_regs_test;
    import misc_cfg_pkg::*;
    logic ref_clk = 1'b0;
    logic nrst, psel, penable, pwrite, pready, pslverr, channel_selected, conv_done;
    logic seq_restart, excitation_out_swap, mux_input_swap, result_valid;
    logic burnout_100na_en, burnout_2ua_en, burnout_10ua_en;
    logic [11:0] paddr;
    logic [31:0] pwdata, prdata;
    logic [2:0] active_setup;
    logic [23:0] conv_data, result_data, a_val, b_val, avg;
    logic [24:0] sum;
    logic [15:0] cv [6] = '{16'h4000, 16'h0100, 16'h4100, 16'h8000, 16'hC300, 16'h4100};
    logic e, m;
    int errors = 0;
    int n_checks = 0;

    always #25 ref_clk = ~ref_clk;

    setup_misc_config_regs setup_misc_config_regs_inst (.*);
    apb_host_model apb_host_model_inst (.*);

    // ------------------------------------------------------------
    // compare, bus and conversion tasks
    // ------------------------------------------------------------
    task automatic cmp(input logic [31:0] got, input logic [31:0] exp);
        n_checks++;
        if (got !== exp) begin
            errors++;
            $display("[FAIL] t=%0t got=%h exp=%h", $time, got, exp);
        end
    endtask

    task automatic cmp1(input logic got, input logic exp);
        n_checks++;
        if (got !== exp) begin
            errors++;
            $display("[FAIL] t=%0t got=%h exp=%h", $time, got, exp);
        end
    endtask

    function automatic logic [11:0] ra(input int n);
        return {SETUP_IDX[n], 2'b00};
    endfunction

    task automatic wr(input logic [11:0] a, input logic [31:0] d, input logic exp_err);
        logic [31:0] rd;
        logic err;
        apb_host_model_inst.xfer(1'b1, a, d, rd, err);
        apb_host_model_inst.go_idle();
        cmp1(err, exp_err);
        @(negedge ref_clk);
        cmp1(seq_restart, ~exp_err);
        @(posedge ref_clk);
    endtask

    // no release afterwards, so reads run back to back
    task automatic rd(input logic [11:0] a, input logic [31:0] exp, input logic exp_err);
        logic [31:0] v;
        logic err;
        apb_host_model_inst.xfer(1'b0, a, 32'h0, v, err);
        cmp(v, exp);
        cmp1(err, exp_err);
    endtask

    task automatic idle();
        apb_host_model_inst.go_idle();
        @(posedge ref_clk);
    endtask

    task automatic conv(input logic [23:0] d, input logic ev, input logic [23:0] ed,
                        input logic ee, input logic em);
        conv_done <= 1'b1;
        conv_data <= d;
        @(posedge ref_clk);
        conv_done <= 1'b0;
        conv_data <= ~d;
        @(negedge ref_clk);
        cmp1(result_valid, ev);
        if (ev) cmp({8'h0, result_data}, {8'h0, ed});
        cmp1(excitation_out_swap, ee);
        cmp1(mux_input_swap, em);
        @(posedge ref_clk);
    endtask

    task automatic results();
        $display("checks %0d errors %0d", n_checks, errors);
        if (errors == 0 && n_checks > 0) begin
            $display("NO MISMATCHES");
        end else begin
            $display("MISMATCHES SEEN");
        end
        $finish;
    endtask

    // ------------------------------------------------------------
    // tests
    // ------------------------------------------------------------
    initial begin
        nrst = 1'b0;
        active_setup = 3'h0;
        channel_selected = 1'b0;
        conv_done = 1'b0;
        conv_data = 24'h0;
        repeat (20) @(posedge ref_clk);
        nrst <= 1'b1;
        @(posedge ref_clk);
        for (int n = 0; n < 8; n++) rd(ra(n), 32'h0, 1'b0);
        idle();
        for (int n = 0; n < 8; n++) begin
            wr(ra(n), 32'hFFFF_FFFF, 1'b0);
            rd(ra(n), {16'h0, CFG_WMASK}, 1'b0);
            idle();
        end
        // unmapped and misaligned: refused, stored nothing, no restart
        wr(12'h304, 32'h0000_0000, 1'b1);
        wr(ra(1) + 12'h002, 32'h0000_0000, 1'b1);
        rd(12'h304, 32'h0, 1'b1);
        rd(ra(1), {16'h0, CFG_WMASK}, 1'b0);
        idle();
        // burnout: setup n holds code n mod 4
        for (int n = 0; n < 8; n++) wr(ra(n), 32'(n % 4), 1'b0);
        channel_selected <= 1'b1;
        for (int n = 0; n < 8; n++) begin
            active_setup <= 3'(n);
            repeat (2) @(posedge ref_clk);
            @(negedge ref_clk);
            cmp({29'h0, burnout_10ua_en, burnout_2ua_en, burnout_100na_en},
                {29'h0, n % 4 == 3, n % 4 == 2, n % 4 == 1});
            @(posedge ref_clk);
        end
        channel_selected <= 1'b0;
        repeat (2) @(posedge ref_clk);
        @(negedge ref_clk);
        cmp({29'h0, burnout_10ua_en, burnout_2ua_en, burnout_100na_en}, 32'h0);
        @(posedge ref_clk);
        // chop modes on setup 0; last entry arms setup 1 only
        active_setup <= 3'h0;
        @(posedge ref_clk);
        a_val = 24'h7FFFFF;
        b_val = 24'h7FFFFD;
        sum = {a_val[23], a_val} + {b_val[23], b_val};
        avg = sum[24:1];
        for (int k = 0; k < 6; k++) begin
            e = (k == 0 || k == 2);
            m = (k == 1 || k == 2);
            wr(ra(0), 32'h0, 1'b0);
            // excitation magnitudes taken as equal when chopping
            wr(ra(k == 5 ? 1 : 0), {16'h0, cv[k]}, 1'b0);
            conv(a_val, !(e | m), a_val, e, m);
            conv(b_val, 1'b1, (e | m) ? avg : b_val, 1'b0, 1'b0);
        end
        results();
    end

    initial begin
        #(10000 * 50);
        errors++;
        results();
    end
endmodule // setup_misc_config_regs_test
